// File: design/spt_translate.v
// Notes on behaviour
// - Address bits 0-3 pick one of sixteen segments.
// - Translation disabled gives direct addressing; a data access to an I/O segment still takes the I/O path.
// - Enabled memory segment without block hit uses paged translation.
// - Data access to I/O segment takes I/O path.
// - Fetch checks enable before segment type.
// - Fetch to I/O segment: forced id else exception.
// - Logical address becomes 52-bit virtual address.
// - Segment id is high part of page number.
// - Segment id plus bits 4-19 form page number.
// - Physical page plus bits 20-31 give address.
// - Segment register field layout as specified.
// - Segment moves allowed only in supervisor mode.
// - Indirect moves index by operand bits 0-3.
// - Entry word 0 field layout as specified.
// - Entry word 1 field layout as specified.
// - Buffer holds page index bits 4-12, bits 13-16 index.
// - Buffer searched first; hit skips table walk unless dirty needs updating.
// - No history update for block or I/O.
// - History updated only with translation enabled.
// - Miss walk sets used and dirty as needed.
// - Hit walks only when dirty needs updating.
// - Hit, used set, dirty clear: write walks.
// - Miss walk loads buffer, and fetch buffer on a fetch.
// - Block hit ignores segment unless I/O.
// Bit numbering below is big-endian: documented bit 0 is bit 31.
`include "spt_defs.vh"
module spt_translate
(
    // Clock and reset.
    input  wire        clk,
    input  wire        reset_n,
    // Access request from the core.
    input  wire        accValid,
    input  wire        accIsFetch,
    input  wire        accIsWrite,
    input  wire [31:0] accAddr,
    input  wire        instrTranslateEnable,
    input  wire        dataTranslateEnable,
    input  wire        blockXlatHit,
    input  wire [31:0] blockXlatAddr,
    // Segment register moves.
    input  wire        segMoveValid,
    input  wire        segMoveWrite,
    input  wire        segMoveIndirect,
    input  wire [3:0]  segMoveImm,
    input  wire [31:0] segMoveIndex,
    input  wire [31:0] segMoveData,
    input  wire        supervisorMode,
    // Table walk result from the walker.
    input  wire        walkDone,
    input  wire        walkFound,
    input  wire [31:0] walkPteWord0,
    input  wire [31:0] walkPteWord1,
    // Translation result.
    output reg  [4:0]  outcome,
    output reg  [31:0] physAddr,
    output reg  [51:0] virtualAddr,
    output reg  [2:0]  cacheModeBits,
    output reg  [1:0]  pageProtectBits,
    output reg         supervisorKey,
    output reg         userKey,
    // Table walk request.
    output reg         walkReq,
    output reg  [39:0] walkVpn,
    output reg         walkSetUsed,
    output reg         walkSetDirty,
    output reg         fetchBufLoad,
    // Segment move answers.
    output reg  [31:0] segReadData,
    output reg         segMoveDone,
    output reg         segMovePrivErr
);
    localparam ST_IDLE = 2'b01;
    localparam ST_WALK = 2'b10;

    reg [31:0] segReg [0:15];
    reg [1:0]  state;
    reg [3:0]  pendSet;
    reg        pendWrite;
    reg        pendFetch;
    reg [11:0] pendOffset;
    reg        bufValid [0:15];
    reg [23:0] bufVsid   [0:15];
    reg [8:0]  bufPi     [0:15];
    reg [19:0] bufPpn    [0:15];
    reg        bufDirty  [0:15];
    reg [2:0]  bufWim    [0:15];
    reg [1:0]  bufPp     [0:15];
    integer    i;

    wire [3:0]  segSel = accAddr[31:28];
    wire [31:0] seg = segReg[segSel];
    wire        segIo = seg[31 - `SPT_SEG_IO_BIT];
    wire [23:0] segVsid = seg[23:0];
    wire [39:0] virtual_page_number = {segVsid, accAddr[27:12]};
    wire [3:0]  setIdx = accAddr[18:15];
    wire        xlatOn = accIsFetch ? instrTranslateEnable
                                    : dataTranslateEnable;
    wire        bufHit = bufValid[setIdx] && bufVsid[setIdx] == segVsid
                      && bufPi[setIdx] == accAddr[27:19];
    wire        needDirty = accIsWrite && !bufDirty[setIdx];
    wire [3:0]  mvIdx = segMoveIndirect ? segMoveIndex[31:28]
                                        : segMoveImm;
    wire [8:0]  busUnit = seg[28:20];

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            outcome <= `SPT_OUT_NONE;
            physAddr <= 32'h00000000;
            virtualAddr <= 52'h0000000000000;
            cacheModeBits <= 3'h0;
            pageProtectBits <= 2'h0;
            supervisorKey <= 1'b0;
            userKey <= 1'b0;
            walkReq <= 1'b0;
            walkVpn <= 40'h0000000000;
            walkSetUsed <= 1'b0;
            walkSetDirty <= 1'b0;
            fetchBufLoad <= 1'b0;
            segReadData <= 32'h00000000;
            segMoveDone <= 1'b0;
            segMovePrivErr <= 1'b0;
            pendSet <= 4'h0;
            pendWrite <= 1'b0;
            pendFetch <= 1'b0;
            pendOffset <= 12'h000;
            for (i = 0; i < `SPT_SEG_COUNT; i = i + 1)
            begin
                segReg[i] <= `SPT_SEG_RESET;
                bufValid[i] <= 1'b0;
                bufVsid[i] <= 24'h000000;
                bufPi[i] <= 9'h000;
                bufPpn[i] <= 20'h00000;
                bufDirty[i] <= 1'b0;
                bufWim[i] <= 3'h0;
                bufPp[i] <= 2'h0;
            end
        end
        else
        begin
            outcome <= `SPT_OUT_NONE;
            walkReq <= 1'b0;
            fetchBufLoad <= 1'b0;
            segMoveDone <= 1'b0;
            segMovePrivErr <= 1'b0;
            if (segMoveValid)
            begin
                segMoveDone <= 1'b1;
                if (!supervisorMode)
                    segMovePrivErr <= 1'b1;
                else if (segMoveWrite)
                    // The I/O format uses bits 3-11 for its unit id.
                    segReg[mvIdx] <= segMoveData[31 - `SPT_SEG_IO_BIT] ?
                        segMoveData :
                        segMoveData & `SPT_SEG_RSVD_MASK;
                else
                    segReadData <= segReg[mvIdx];
            end
            case (state)
                ST_IDLE:
                begin
                    if (accValid)
                    begin
                        supervisorKey <= seg[31 - `SPT_SEG_SKEY_BIT];
                        userKey <= seg[31 - `SPT_SEG_UKEY_BIT];
                        virtualAddr <= {virtual_page_number, accAddr[11:0]};
                        if (accIsFetch && !instrTranslateEnable)
                        begin
                            outcome <= `SPT_OUT_DIRECT;
                            physAddr <= accAddr;
                        end
                        else if (segIo && accIsFetch)
                        begin
                            // Memory-forced fetches go out on the I/O path.
                            if (busUnit == `SPT_MEM_FORCED_ID)
                                outcome <= `SPT_OUT_IO;
                            else
                                outcome <= `SPT_OUT_EXC;
                            physAddr <= accAddr;
                        end
                        else if (segIo)
                        begin
                            outcome <= `SPT_OUT_IO;
                            physAddr <= accAddr;
                        end
                        else if (!xlatOn)
                        begin
                            outcome <= `SPT_OUT_DIRECT;
                            physAddr <= accAddr;
                        end
                        else if (blockXlatHit)
                        begin
                            outcome <= `SPT_OUT_DIRECT;
                            physAddr <= blockXlatAddr;
                        end
                        else if (bufHit)
                        begin
                            outcome <= `SPT_OUT_HIT;
                            physAddr <= {bufPpn[setIdx],
                                         accAddr[11:0]};
                            cacheModeBits <= bufWim[setIdx];
                            pageProtectBits <= bufPp[setIdx];
                            if (needDirty)
                            begin
                                // Only the dirty flag needs the walk.
                                walkReq <= 1'b1;
                                walkVpn <= virtual_page_number;
                                walkSetUsed <= 1'b0;
                                walkSetDirty <= 1'b1;
                                bufDirty[setIdx] <= 1'b1;
                            end
                        end
                        else
                        begin
                            outcome <= `SPT_OUT_WALK;
                            walkReq <= 1'b1;
                            walkVpn <= virtual_page_number;
                            walkSetUsed <= 1'b1;
                            walkSetDirty <= accIsWrite;
                            pendSet <= setIdx;
                            pendWrite <= accIsWrite;
                            pendFetch <= accIsFetch;
                            pendOffset <= accAddr[11:0];
                            bufVsid[setIdx] <= segVsid;
                            bufPi[setIdx] <= accAddr[27:19];
                            state <= ST_WALK;
                        end
                    end
                end
                ST_WALK:
                begin
                    // Further accesses are ignored until the walk finishes.
                    if (walkDone)
                    begin
                        state <= ST_IDLE;
                        if (walkFound && walkPteWord0[`SPT_PTE0_VALID])
                        begin
                            bufValid[pendSet] <= 1'b1;
                            bufPpn[pendSet] <= walkPteWord1[31:12];
                            bufDirty[pendSet] <=
                                walkPteWord1[`SPT_PTE1_DIRTY] | pendWrite;
                            bufWim[pendSet] <= walkPteWord1[6:4];
                            bufPp[pendSet] <= walkPteWord1[1:0];
                            cacheModeBits <= walkPteWord1[6:4];
                            pageProtectBits <= walkPteWord1[1:0];
                            physAddr <= {walkPteWord1[31:12],
                                         pendOffset};
                            fetchBufLoad <= pendFetch;
                            outcome <= `SPT_OUT_HIT;
                        end
                        else
                        begin
                            bufValid[pendSet] <= 1'b0;
                            outcome <= `SPT_OUT_EXC;
                        end
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule

// File: shared/spt_defs.vh
`ifndef SPT_DEFS_VH
`define SPT_DEFS_VH
`define SPT_SEG_COUNT      16
`define SPT_SEG_IO_BIT     0
`define SPT_SEG_SKEY_BIT   1
`define SPT_SEG_UKEY_BIT   2
`define SPT_SEG_VIRTUAL_SEGMENT_ID_LSB   8
`define SPT_SEG_RESET      32'h00000000
`define SPT_SEG_RSVD_MASK  32'hE0FFFFFF
`define SPT_MEM_FORCED_ID  9'h07F
`define SPT_PTE0_VALID     31
`define SPT_PTE0_HASH      6
`define SPT_PTE1_USED      8
`define SPT_PTE1_DIRTY     7
`define SPT_BUF_SETS       16
`define SPT_OUT_NONE       5'h00
`define SPT_OUT_DIRECT     5'h01
`define SPT_OUT_IO         5'h02
`define SPT_OUT_HIT        5'h04
`define SPT_OUT_WALK       5'h08
`define SPT_OUT_EXC        5'h10
`endif

// File: verification/spt_translate_properties.sv
module spt_translate_properties
(
    // Clock, reset and access.
    input wire        clk,
    input wire        reset_n,
    input wire        accValid,
    input wire        accIsFetch,
    input wire        accIsWrite,
    input wire [31:0] accAddr,
    input wire        instrTranslateEnable,
    input wire        segMoveValid,
    input wire        supervisorMode,
    input wire        walkDone,
    // Results.
    input wire [4:0]  outcome,
    input wire [31:0] physAddr,
    input wire [51:0] virtualAddr,
    input wire        walkReq,
    input wire [39:0] walkVpn,
    input wire        walkSetUsed,
    input wire        walkSetDirty,
    input wire        segMovePrivErr
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  pend;
    wire taken;
    // Requests made while a walk is pending are refused, so mask them.
    assign taken = accValid && !pend && outcome != 5'h08;
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pend <= 1'b0;
        else if (outcome == 5'h08)
            pend <= 1'b1;
        else if (walkDone)
            pend <= 1'b0;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence sTaken;
        taken;
    endsequence
    sequence sWalkEnd;
        pend && walkDone;
    endsequence
    a_one_hot: assert property (outcome != 5'h00 |-> $onehot(outcome))
        else $error("outcome not one-hot");
    a_answer_next: assert property (sTaken |=> outcome != 5'h00)
        else $error("access got no outcome");
    a_fetch_direct: assert property (
        sTaken and accIsFetch && !instrTranslateEnable |=> outcome == 5'h01)
        else $error("fetch with translation off not direct");
    a_walk_marks: assert property (
        outcome == 5'h08 |-> walkReq && walkSetUsed)
        else $error("miss walk without used update");
    a_walk_dirty: assert property (
        sTaken ##1 outcome == 5'h08 |-> walkSetDirty == $past(accIsWrite))
        else $error("miss walk dirty flag wrong");
    a_offset_kept: assert property (
        sTaken ##1 outcome == 5'h04 |-> physAddr[11:0] == $past(accAddr[11:0]))
        else $error("byte offset altered");
    a_vpn_form: assert property (
        sTaken ##1 outcome == 5'h08 |-> virtualAddr[27:0] == $past(accAddr[27:0]))
        else $error("virtual address low part wrong");
    a_walk_vpn: assert property (walkReq |-> walkVpn == virtualAddr[51:12])
        else $error("walk page number wrong");
    a_walk_end: assert property (
        sWalkEnd |=> outcome == 5'h04 || outcome == 5'h10)
        else $error("walk end without result");
    a_no_history: assert property (
        outcome == 5'h01 || outcome == 5'h02 |-> !walkReq)
        else $error("history walk on direct or io");
    a_priv_block: assert property (
        segMoveValid && !supervisorMode |=> segMovePrivErr)
        else $error("user segment move not refused");
endmodule
bind spt_translate spt_translate_properties spt_translate_properties_inst (
    .clk(clk), .reset_n(reset_n), .accValid(accValid),
    .accIsFetch(accIsFetch), .accIsWrite(accIsWrite), .accAddr(accAddr),
    .instrTranslateEnable(instrTranslateEnable), .walkDone(walkDone),
    .segMoveValid(segMoveValid), .supervisorMode(supervisorMode),
    .outcome(outcome), .physAddr(physAddr), .virtualAddr(virtualAddr),
    .walkReq(walkReq), .walkVpn(walkVpn), .walkSetUsed(walkSetUsed),
    .walkSetDirty(walkSetDirty), .segMovePrivErr(segMovePrivErr));

// File: verification/spt_translate_tb.sv
module spt_translate_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, reset_n = 0, accValid = 0, accIsFetch = 0;
    logic        accIsWrite = 0, instrTranslateEnable = 0;
    logic        dataTranslateEnable = 0, blockXlatHit = 0, found = 0;
    logic        segMoveValid = 0, segMoveWrite = 0, segMoveIndirect = 0;
    logic        supervisorMode = 0, supervisorKey, userKey, walkReq;
    logic        walkSetUsed, walkSetDirty, fetchBufLoad, segMoveDone;
    logic        segMovePrivErr, walkDone, walkFound;
    logic [3:0]  segMoveImm = 0, delay = 1;
    logic [19:0] physical_page_number = 0;
    logic [31:0] accAddr = 0, blockXlatAddr = 0, segMoveIndex = 0;
    logic [31:0] segMoveData = 0, segReadData, physAddr, rnd = 71996;
    logic [31:0] walkPteWord0, walkPteWord1;
    logic [51:0] virtualAddr;
    logic [39:0] walkVpn;
    logic [4:0]  outcome;
    logic [2:0]  cacheModeBits;
    logic [1:0]  pageProtectBits;
    logic [37:0] e, expQ[$];
    int          bad_count = 0, check_count = 0, loads = 0;
    always #10 clk = ~clk;
    spt_translate spt_translate_inst (.*);
    spt_walker_model spt_walker_model_inst (.*);
    task automatic check(string name, logic [37:0] exp, logic [37:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic seg(logic wr, logic ind, logic [3:0] n, logic [31:0] d);
        @(posedge clk);
        segMoveValid <= 1;
        segMoveWrite <= wr;
        segMoveIndirect <= ind;
        segMoveImm <= ind ? ~n : n;
        segMoveIndex <= {n, rnd[27:0]};
        segMoveData <= d;
        @(posedge clk);
        segMoveValid <= 0;
        #1;
        check("segMoveDone", 38'h1, {37'h0, segMoveDone});
        if (!wr)
            check("segReadData", {6'h0, d}, {6'h0, segReadData});
    endtask
    task automatic acc(logic f, logic w, logic [31:0] a, logic [37:0] e1,
                       logic [37:0] e2 = 38'h0);
        @(posedge clk);
        accValid <= 1;
        accIsFetch <= f;
        accIsWrite <= w;
        accAddr <= a;
        expQ.push_back(e1);
        if (e2 != 0)
            expQ.push_back(e2);
        @(posedge clk);
        accValid <= 0;
        for (int n = 0; n < 40 && expQ.size() > 0; n++) @(posedge clk);
        // Let a dirty-update walk of the partner finish before moving on.
        repeat (12) @(posedge clk);
    endtask
    always @(negedge clk)
    begin
        if (fetchBufLoad === 1'b1)
            loads++;
        if (reset_n && outcome !== 5'h00)
        begin
            e = expQ.size() > 0 ? expQ.pop_front() : '1;
            check("result", e, {walkReq, outcome,
                  (e[32] | e[34]) ? physAddr : e[31:0]});
        end
    end
    initial
    begin
        #200us;
        bad_count++;
        finish_test();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        reset_n <= 1;
        #1 check("idle", 38'h0, {walkReq, outcome, physAddr});
        supervisorMode <= 1;
        seg(1, 0, 1, 32'h60ABCDE1);
        seg(1, 1, 2, 32'h87F00000);
        seg(1, 0, 3, 32'h81000000);
        seg(0, 1, 1, 32'h60ABCDE1);
        seg(0, 0, 2, 32'h87F00000);
        supervisorMode <= 0;
        seg(1, 0, 1, 32'h00000000);
        supervisorMode <= 1;
        seg(0, 0, 1, 32'h60ABCDE1);
        $display("segment moves done");
        acc(1, 0, 32'h20000ABC, {6'h01, 32'h20000ABC});
        acc(0, 0, 32'h20000010, {6'h02, 32'h0});
        acc(0, 0, 32'h10000010, {6'h01, 32'h10000010});
        instrTranslateEnable <= 1;
        dataTranslateEnable <= 1;
        acc(1, 0, 32'h20000100, {6'h02, 32'h0});
        acc(1, 0, 32'h30000100, {6'h10, 32'h0});
        blockXlatHit <= 1;
        blockXlatAddr <= 32'h00ABC000;
        acc(0, 0, 32'h12345678, {6'h01, 32'h00ABC000});
        check("keys", 38'h3, {36'h0, supervisorKey, userKey});
        blockXlatHit <= 0;
        physical_page_number <= 20'hFEDCB;
        found <= 1;
        delay <= 7;
        acc(0, 0, 32'h12345678, {6'h28, 32'h0}, {6'h04, 32'hFEDCB678});
        acc(0, 1, 32'h12345ABC, {6'h24, 32'hFEDCBABC});
        acc(0, 1, 32'h12345004, {6'h04, 32'hFEDCB004});
        for (int i = 0; i < 8; i++)
        begin
            rnd ^= rnd << 13;
            rnd ^= rnd >> 17;
            rnd ^= rnd << 5;
            acc(0, 0, {20'h12345, rnd[11:0]}, {6'h04, 20'hFEDCB, rnd[11:0]});
        end
        check("wimpp", 38'h16, {33'h0, cacheModeBits, pageProtectBits});
        $display("paged hits done");
        found <= 0;
        delay <= 1;
        acc(0, 0, 32'h1ABCD000, {6'h28, 32'h0}, {6'h10, 32'h0});
        found <= 1;
        acc(1, 0, 32'h1ABCE000, {6'h28, 32'h0}, {6'h04, 32'hFEDCB000});
        check("fetchBufLoad", 38'h1, 38'(loads));
        $display("table walks done");
        finish_test();
    end
endmodule

// File: verification/spt_walker_model.sv
module spt_walker_model
(
    // Walk request from the block.
    input  wire        clk,
    input  wire        walkReq,
    input  wire [39:0] walkVpn,
    input  wire        walkSetUsed,
    input  wire        walkSetDirty,
    // Table contents and speed.
    input  wire        found,
    input  wire [19:0] physical_page_number,
    input  wire [3:0]  delay,
    // Walk answer.
    output reg         walkDone = 1'b0,
    output reg         walkFound = 1'b0,
    output reg  [31:0] walkPteWord0 = 32'h00000000,
    output reg  [31:0] walkPteWord1 = 32'h00000000
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge clk)
    begin
        if (walkReq)
        begin
            repeat (delay) @(posedge clk);
            walkFound <= found;
            walkPteWord0 <= {found, walkVpn[39:16], 1'b0, walkVpn[15:10]};
            walkPteWord1 <= {physical_page_number, 3'h0, walkSetUsed, walkSetDirty,
                             3'h5, 2'h0, 2'h2};
            walkDone <= 1'b1;
            @(posedge clk);
            walkDone <= 1'b0;
            // Stale words are scrambled so nothing relies on them.
            walkPteWord0 <= ~walkPteWord0;
            walkPteWord1 <= ~walkPteWord1;
        end
    end
endmodule
